// file: rtl/pllcc_pkg.sv
// Package for the PLL clock control registers: offsets, bit positions,
// reset values and the register bus carrier.
// Assumes a single 40 MHz bus clock and an 8-bit register port.
package pllcc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [1:0] ADDR_PLL_CONTROL   = 2'h0;
  localparam logic [1:0] ADDR_PLL_BANDWIDTH = 2'h1;
  localparam logic [1:0] ADDR_PLL_PROGRAM   = 2'h2;

  // ==========================================================================
  // Control register bits
  localparam int BIT_LOCK_IRQ_ENABLE  = 7;
  localparam int BIT_LOCK_CHANGE_FLAG = 6;
  localparam int BIT_PLL_ENABLE       = 5;
  localparam int BIT_BASE_CLOCK_SEL   = 4;
  localparam logic [3:0] CTRL_LOW_ONES = 4'hf;

  // Bandwidth control register bits
  localparam int BIT_AUTO_BANDWIDTH  = 7;
  localparam int BIT_LOCK_INDICATOR  = 6;
  localparam int BIT_ACQ_TRACKING    = 5;
  localparam int BIT_CRYSTAL_LOSS    = 4;

  // Programming register fields
  localparam int MUL_MSB = 7;
  localparam int MUL_LSB = 4;
  localparam int VRS_MSB = 3;
  localparam int VRS_LSB = 0;

  // ==========================================================================
  // Reset values and counts
  localparam logic       RST_PLL_ENABLE  = 1'b1;
  localparam logic [3:0] RST_MULTIPLIER  = 4'h6;
  localparam logic [3:0] RST_VCO_RANGE   = 4'h6;
  localparam logic [1:0] SWITCH_EDGES    = 2'h3;
  localparam logic [5:0] XLD_EDGE_FACTOR = 6'h04;

  // ==========================================================================
  // Register bus request carrier
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pllcc_bus_req_t;

endpackage

// file: rtl/pllcc_clk_sel.sv
// Base clock selector: divide-by-two of the chosen source with a quiet switch.
// Assumes source edges arrive as one-cycle pulses already synchronised.
`timescale 1ns/100ps
module pllcc_clk_sel
  import pllcc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_sel,
  input  wire logic i_xclk_rise,
  input  wire logic i_vclk_rise,
  output logic      o_clk,
  output logic      o_busy
);

  typedef enum logic {PLLCC_SEL_RUN, PLLCC_SEL_SWITCH} pllcc_sel_state_t;

  pllcc_sel_state_t state_r;
  logic             cur_sel_r;
  logic [1:0]       cnt_x_r;
  logic [1:0]       cnt_v_r;
  logic             out_r;

  // ==========================================================================
  // Switch sequencing: hold output until three edges of each source
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r   <= PLLCC_SEL_RUN;
      cur_sel_r <= 1'b0;
      cnt_x_r   <= 2'h0;
      cnt_v_r   <= 2'h0;
    end else begin
      case (state_r)
        PLLCC_SEL_RUN: begin
          if (i_sel != cur_sel_r) begin
            state_r <= PLLCC_SEL_SWITCH;
            cnt_x_r <= 2'h0;
            cnt_v_r <= 2'h0;
          end
        end
        PLLCC_SEL_SWITCH: begin
          if (i_xclk_rise && cnt_x_r != SWITCH_EDGES) cnt_x_r <= cnt_x_r + 2'h1;
          if (i_vclk_rise && cnt_v_r != SWITCH_EDGES) cnt_v_r <= cnt_v_r + 2'h1;
          if (cnt_x_r == SWITCH_EDGES && cnt_v_r == SWITCH_EDGES) begin
            cur_sel_r <= i_sel;
            state_r   <= PLLCC_SEL_RUN;
          end
        end
        default: state_r <= PLLCC_SEL_RUN;
      endcase
    end
  end

  // Divide the selected source by two; static while switching
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_r <= 1'b0;
    end else if (state_r == PLLCC_SEL_RUN && i_sel == cur_sel_r) begin
      if (cur_sel_r ? i_vclk_rise : i_xclk_rise) out_r <= ~out_r;
    end
  end

  assign o_clk  = out_r;
  assign o_busy = (state_r == PLLCC_SEL_SWITCH);

endmodule // pllcc_clk_sel

// file: rtl/pllcc_top.sv
// PLL clock control registers: control, bandwidth control and programming.
// Assumes analog lock/tracking levels and source clocks arrive asynchronously.
//
// Overview of operation
// - Lock interrupt enable reads zero and ignores writes while automatic mode off.
// - Lock change flag sets on every lock toggle; irq when flag and enable.
// - Flag sets on lock toggle whatever the interrupt enable holds.
// - A control register read clears the flag unless a lock toggle comes in the same cycle; the flag is not writable.
// - In manual mode flag and lock read zero and no irq is raised.
// - While clock select is one, PLL enable stays one.
// - Clock select stays zero while PLL off or range field zero.
// - From PLL off, one write cannot both enable and select VCO clock.
// - Programming register ignores writes while PLL enable is one.
// - Select one gives VCO/2, zero crystal/2; switch holds three edges each.
// - Reset sets PLL enable and clears the other control and status bits.
// - Low four control register bits read as ones.
// - In automatic mode lock indicator shows VCO at programmed frequency.
// - Acquisition bit reports tracking in auto mode, forces filter in manual.
// - Manual acquisition value is kept during auto mode and restored.
// - Crystal loss test runs 4 x multiplier VCO cycles; reads zero unless selected.
// - Multiplier is the upper nibble, zero acts as one, resets to six.
// - Range is the lower nibble, resets to six; zero disables PLL and select.
// - VCO clock may be selected while unlocked; software checks lock first.
// - Wait mode leaves the clock generator state unchanged.
// - PLL enable never changes in the write that changes clock select.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module pllcc_top
  import pllcc_pkg::*;
(
  input  wire logic           I_CLK,
  input  wire logic           I_RSTN,
  input  wire pllcc_bus_req_t I_BUS,
  output logic [7:0]          O_RDATA,
  input  wire logic           I_LOCKED,
  input  wire logic           I_TRACKING,
  input  wire logic           I_CRYSTAL_CLOCK,
  input  wire logic           I_VCO_CLOCK,
  output logic                O_PLL_ENABLE,
  output logic                O_FILTER_TRACKING,
  output logic                O_AUTO_BANDWIDTH,
  output logic [3:0]          O_FEEDBACK_MULTIPLIER,
  output logic [3:0]          O_VCO_RANGE_SELECT,
  output logic                O_BASE_CLOCK_OUT,
  output logic                O_SWITCH_BUSY,
  output logic                O_CLOCKGEN_IRQ
);

  // ==========================================================================
  // Declarations
  logic       lock_irq_enable_r;
  logic       lock_change_flag_r;
  logic       pll_enable_r;
  logic       base_clock_select_r;
  logic       auto_bandwidth_r;
  logic       acq_manual_r;
  logic       crystal_loss_r;
  logic       xld_busy_r;
  logic       xtal_seen_r;
  logic [5:0] xld_cnt_r;
  logic [3:0] feedback_multiplier_r;
  logic [3:0] vco_range_select_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [2:0] lock_sync_r;
  logic [1:0] trk_sync_r;
  logic [2:0] xclk_sync_r;
  logic [2:0] vclk_sync_r;
  logic       wr_ctrl;
  logic       wr_bw;
  logic       wr_prog;
  logic       rd_ctrl;
  logic       lock_now;
  logic       lock_toggle;
  logic       xclk_rise;
  logic       vclk_rise;
  logic       range_zero;
  logic       sel_change;
  logic [3:0] mul_eff;
  logic [5:0] xld_limit;

  // ==========================================================================
  // Address decode
  assign wr_ctrl = I_BUS.wr && (I_BUS.addr == ADDR_PLL_CONTROL);
  assign wr_bw   = I_BUS.wr && (I_BUS.addr == ADDR_PLL_BANDWIDTH);
  assign wr_prog = I_BUS.wr && (I_BUS.addr == ADDR_PLL_PROGRAM);
  assign rd_ctrl = I_BUS.rd && (I_BUS.addr == ADDR_PLL_CONTROL);

  // ==========================================================================
  // Input synchronisers; edge logic reads only second stage onward
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lock_sync_r <= 3'h0;
      trk_sync_r  <= 2'h0;
      xclk_sync_r <= 3'h0;
      vclk_sync_r <= 3'h0;
    end else begin
      lock_sync_r <= {lock_sync_r[1:0], I_LOCKED};
      trk_sync_r  <= {trk_sync_r[0], I_TRACKING};
      xclk_sync_r <= {xclk_sync_r[1:0], I_CRYSTAL_CLOCK};
      vclk_sync_r <= {vclk_sync_r[1:0], I_VCO_CLOCK};
    end
  end

  assign lock_now    = lock_sync_r[1];
  assign lock_toggle = lock_sync_r[1] ^ lock_sync_r[2];
  assign xclk_rise   = xclk_sync_r[1] & ~xclk_sync_r[2];
  assign vclk_rise   = vclk_sync_r[1] & ~vclk_sync_r[2];
  assign range_zero  = (vco_range_select_r == 4'h0);
  assign sel_change  = I_BUS.wdata[BIT_BASE_CLOCK_SEL] != base_clock_select_r;

  // ==========================================================================
  // Control register: interrupt enable
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lock_irq_enable_r <= 1'b0;
    end else if (!auto_bandwidth_r) begin
      lock_irq_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      lock_irq_enable_r <= I_BUS.wdata[BIT_LOCK_IRQ_ENABLE];
    end
  end

  // Lock change flag: set wins over read clear
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lock_change_flag_r <= 1'b0;
    end else if (lock_toggle) begin
      lock_change_flag_r <= 1'b1;
    end else if (rd_ctrl) begin
      lock_change_flag_r <= 1'b0;
    end
  end

  // PLL enable: held while selected, fixed in a write that changes select
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pll_enable_r <= RST_PLL_ENABLE;
    end else if (wr_ctrl && !base_clock_select_r && !sel_change) begin
      pll_enable_r <= I_BUS.wdata[BIT_PLL_ENABLE];
    end
  end

  // Base clock select: set only from an enabled PLL with nonzero range
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      base_clock_select_r <= 1'b0;
    end else if (!pll_enable_r || range_zero) begin
      base_clock_select_r <= 1'b0;
    end else if (wr_ctrl) begin
      base_clock_select_r <= I_BUS.wdata[BIT_BASE_CLOCK_SEL];
    end
  end

  // ==========================================================================
  // Bandwidth control: auto bit and hidden manual acquisition store
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      auto_bandwidth_r <= 1'b0;
      acq_manual_r     <= 1'b0;
    end else if (wr_bw) begin
      auto_bandwidth_r <= I_BUS.wdata[BIT_AUTO_BANDWIDTH];
      if (!auto_bandwidth_r) acq_manual_r <= I_BUS.wdata[BIT_ACQ_TRACKING];
    end
  end

  // Crystal loss test: count 4 x N VCO edges, watch for a crystal edge
  assign mul_eff   = (feedback_multiplier_r == 4'h0) ? 4'h1 : feedback_multiplier_r;
  assign xld_limit = 6'(XLD_EDGE_FACTOR * {2'h0, mul_eff});

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      crystal_loss_r <= 1'b0;
      xld_busy_r     <= 1'b0;
      xtal_seen_r    <= 1'b0;
      xld_cnt_r      <= 6'h00;
    end else if (wr_bw && I_BUS.wdata[BIT_CRYSTAL_LOSS] && base_clock_select_r) begin
      crystal_loss_r <= 1'b0;
      xld_busy_r     <= 1'b1;
      xtal_seen_r    <= 1'b0;
      xld_cnt_r      <= 6'h00;
    end else if (!base_clock_select_r) begin
      crystal_loss_r <= 1'b0;
      xld_busy_r     <= 1'b0;
    end else if (xld_busy_r) begin
      if (xclk_rise) xtal_seen_r <= 1'b1;
      if (vclk_rise) xld_cnt_r <= xld_cnt_r + 6'h01;
      if (xld_cnt_r == xld_limit) begin
        xld_busy_r     <= 1'b0;
        crystal_loss_r <= ~(xtal_seen_r | xclk_rise);
      end
    end
  end

  // ==========================================================================
  // Programming register: locked while PLL enabled
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      feedback_multiplier_r <= RST_MULTIPLIER;
      vco_range_select_r    <= RST_VCO_RANGE;
    end else if (wr_prog && !pll_enable_r) begin
      feedback_multiplier_r <= I_BUS.wdata[MUL_MSB:MUL_LSB];
      vco_range_select_r    <= I_BUS.wdata[VRS_MSB:VRS_LSB];
    end
  end

  // ==========================================================================
  // Read data mux, registered for the next cycle
  always_comb begin
    rdata_nxt = 8'h00;
    if (I_BUS.addr == ADDR_PLL_CONTROL) begin
      rdata_nxt[BIT_LOCK_IRQ_ENABLE]  = lock_irq_enable_r;
      rdata_nxt[BIT_LOCK_CHANGE_FLAG] = lock_change_flag_r & auto_bandwidth_r;
      rdata_nxt[BIT_PLL_ENABLE]       = pll_enable_r;
      rdata_nxt[BIT_BASE_CLOCK_SEL]   = base_clock_select_r;
      rdata_nxt[3:0]                  = CTRL_LOW_ONES;
    end else if (I_BUS.addr == ADDR_PLL_BANDWIDTH) begin
      rdata_nxt[BIT_AUTO_BANDWIDTH] = auto_bandwidth_r;
      rdata_nxt[BIT_LOCK_INDICATOR] = auto_bandwidth_r & lock_now;
      rdata_nxt[BIT_ACQ_TRACKING]   = auto_bandwidth_r ? trk_sync_r[1] : acq_manual_r;
      rdata_nxt[BIT_CRYSTAL_LOSS]   = base_clock_select_r & crystal_loss_r;
    end else if (I_BUS.addr == ADDR_PLL_PROGRAM) begin
      rdata_nxt = {feedback_multiplier_r, vco_range_select_r};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_r <= 8'h00;
    end else if (I_BUS.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Base clock selector
  pllcc_clk_sel u_clk_sel (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_sel       (base_clock_select_r),
    .i_xclk_rise (xclk_rise),
    .i_vclk_rise (vclk_rise),
    .o_clk       (O_BASE_CLOCK_OUT),
    .o_busy      (O_SWITCH_BUSY)
  );

  // Outputs
  assign O_RDATA               = rdata_r;
  assign O_PLL_ENABLE          = pll_enable_r & ~range_zero;
  assign O_FILTER_TRACKING     = auto_bandwidth_r ? trk_sync_r[1] : acq_manual_r;
  assign O_AUTO_BANDWIDTH      = auto_bandwidth_r;
  assign O_FEEDBACK_MULTIPLIER = mul_eff;
  assign O_VCO_RANGE_SELECT    = vco_range_select_r;
  assign O_CLOCKGEN_IRQ        = auto_bandwidth_r & lock_irq_enable_r & lock_change_flag_r;

  // ==========================================================================
  // Checks
  chk_ie_manual_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !auto_bandwidth_r |=> !lock_irq_enable_r)
    else $error("Interrupt enable set in manual mode");

  chk_flag_on_toggle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    lock_toggle |=> lock_change_flag_r)
    else $error("Lock toggle did not set flag");

  chk_flag_read_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    rd_ctrl && !lock_toggle |=> !lock_change_flag_r)
    else $error("Control read did not clear flag");

  chk_irq_level: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_CLOCKGEN_IRQ |-> auto_bandwidth_r && lock_change_flag_r && lock_irq_enable_r)
    else $error("Irq without auto, flag and enable");

  chk_enable_held: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    base_clock_select_r |=> pll_enable_r)
    else $error("PLL enable cleared while selected");

  chk_select_guard: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !pll_enable_r && wr_ctrl |=> !base_clock_select_r)
    else $error("VCO clock selected in one write from PLL off");

  chk_prog_locked: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    pll_enable_r && wr_prog |=> $stable(feedback_multiplier_r) && $stable(vco_range_select_r))
    else $error("Programming register changed while PLL on");

  chk_range_zero_sel: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    range_zero ##1 range_zero |-> !base_clock_select_r && !O_PLL_ENABLE)
    else $error("Select or enable active with zero range");

  chk_ctrl_low_ones: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    rd_ctrl |=> O_RDATA[3:0] == CTRL_LOW_ONES)
    else $error("Control low bits not ones");

  // Write guards and status paths
  chk_en_sel_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    wr_ctrl && sel_change |=> $stable(pll_enable_r))
    else $error("PLL enable changed in a select write");

  chk_sel_needs_en: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    wr_ctrl && (!pll_enable_r || range_zero) |=> !base_clock_select_r)
    else $error("Select set while PLL off or range zero");

  chk_irq_on_toggle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    auto_bandwidth_r && lock_irq_enable_r && lock_toggle && !wr_ctrl && !wr_bw |=> O_CLOCKGEN_IRQ)
    else $error("Lock toggle with enable gave no irq");

  chk_irq_read_clear: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    rd_ctrl && !lock_toggle |=> !O_CLOCKGEN_IRQ)
    else $error("Irq still high after control read");

  chk_acq_store_kept: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    wr_bw && auto_bandwidth_r |=> $stable(acq_manual_r))
    else $error("Stored acquisition bit changed in auto mode");

  chk_acq_manual_wr: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    wr_bw && !auto_bandwidth_r |=> acq_manual_r == $past(I_BUS.wdata[BIT_ACQ_TRACKING]))
    else $error("Manual acquisition write not taken");

  chk_prog_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !pll_enable_r && wr_prog |=> {feedback_multiplier_r, vco_range_select_r} == $past(I_BUS.wdata))
    else $error("Programming write lost while PLL off");

  chk_xld_unselected: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !base_clock_select_r |=> !crystal_loss_r)
    else $error("Crystal loss set with crystal selected");

  chk_clk_static: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_SWITCH_BUSY |=> $stable(O_BASE_CLOCK_OUT))
    else $error("Base clock moved during switch");

  chk_ie_auto_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    auto_bandwidth_r && wr_ctrl |=> lock_irq_enable_r == $past(I_BUS.wdata[BIT_LOCK_IRQ_ENABLE]))
    else $error("Interrupt enable write lost in auto mode");

  chk_mul_zero_one: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    feedback_multiplier_r == 4'h0 |-> O_FEEDBACK_MULTIPLIER == 4'h1)
    else $error("Zero multiplier not shown as one");

endmodule // pllcc_top

// file: testbench/pllcc_top_test.sv
// Self-checking bench for the PLL clock control registers.
// Assumes the package offsets and bit layout; the bench plays bus master,
// analog lock and tracking levels, and both slow source clocks.
`timescale 1ns/100ps
module pllcc_top_test
  import pllcc_pkg::*;
;
  `define CHK(got, exp) check(got, exp)

  // ==========================================================================
  // Signals
  logic           clk;
  logic           rstn;
  pllcc_bus_req_t bus;
  logic [7:0]     rdata;
  logic           locked;
  logic           tracking;
  logic           xclk;
  logic           vclk;
  logic           xtal_run;
  logic           pll_enable;
  logic           filter_tracking;
  logic           auto_bw;
  logic [3:0]     mult;
  logic [3:0]     vrange;
  logic           base_out;
  logic           switch_busy;
  logic           irq;
  logic [7:0]     d;
  int             n;
  int             fail_count;
  int             n_checks;
  int             cycles;

  // ==========================================================================
  // Device under test
  pllcc_top u_dut (
    .I_CLK                 (clk),
    .I_RSTN                (rstn),
    .I_BUS                 (bus),
    .O_RDATA               (rdata),
    .I_LOCKED              (locked),
    .I_TRACKING            (tracking),
    .I_CRYSTAL_CLOCK       (xclk),
    .I_VCO_CLOCK           (vclk),
    .O_PLL_ENABLE          (pll_enable),
    .O_FILTER_TRACKING     (filter_tracking),
    .O_AUTO_BANDWIDTH      (auto_bw),
    .O_FEEDBACK_MULTIPLIER (mult),
    .O_VCO_RANGE_SELECT    (vrange),
    .O_BASE_CLOCK_OUT      (base_out),
    .O_SWITCH_BUSY         (switch_busy),
    .O_CLOCKGEN_IRQ        (irq)
  );

  // ==========================================================================
  // Bus clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Source clocks: crystal period 6 cycles, VCO period 4 cycles
  always @(posedge clk) begin
    if (xtal_run && (cycles % 3 == 0)) xclk <= ~xclk; // Stops when crystal lost
    if (cycles % 2 == 0) vclk <= ~vclk;
  end

  // Cycle count and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      conclude();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Wait for the selector to settle, then count output rising edges
  task automatic measure(output int cnt);
    int   k;
    logic prev;
    k = 0;
    repeat (4) @(posedge clk);
    while (switch_busy !== 1'b0 && k < 200) begin
      @(posedge clk);
      k = k + 1;
    end
    `CHK({7'h00, switch_busy}, 8'h00);
    cnt = 0;
    prev = base_out;
    repeat (240) begin
      @(posedge clk);
      #1;
      if (base_out === 1'b1 && prev === 1'b0) cnt = cnt + 1;
      prev = base_out;
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    bus = '0; rstn = 1'b0; locked = 1'b0; tracking = 1'b0;
    xclk = 1'b0; vclk = 1'b0; xtal_run = 1'b1;
    fail_count = 0; n_checks = 0; cycles = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and unmapped address
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h00);
    rd(ADDR_PLL_PROGRAM, d);   `CHK(d, 8'h66);
    `CHK({3'h0, pll_enable, mult}, 8'h16);
    `CHK({4'h0, vrange}, 8'h06);
    rd(2'h3, d);               `CHK(d, 8'h00);
    // Programming locked while PLL on
    wr(ADDR_PLL_PROGRAM, 8'h3a);
    rd(ADDR_PLL_PROGRAM, d);   `CHK(d, 8'h66);
    // From off, one write cannot enable and select together
    wr(ADDR_PLL_CONTROL, 8'h00);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h0f);
    wr(ADDR_PLL_CONTROL, 8'h30);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d & 8'h10, 8'h00);
    wr(ADDR_PLL_CONTROL, 8'h00);
    // Range zero keeps PLL off and blocks select
    wr(ADDR_PLL_PROGRAM, 8'h50);
    rd(ADDR_PLL_PROGRAM, d);   `CHK(d, 8'h50);
    wr(ADDR_PLL_CONTROL, 8'h20);
    `CHK({7'h00, pll_enable}, 8'h00);
    wr(ADDR_PLL_CONTROL, 8'h30);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    // Multiplier zero acts as one
    wr(ADDR_PLL_CONTROL, 8'h00);
    wr(ADDR_PLL_PROGRAM, 8'h07);
    rd(ADDR_PLL_PROGRAM, d);   `CHK(d, 8'h07);
    `CHK({4'h0, mult}, 8'h01);
    // Two writes select the VCO clock, unlocked allowed
    wr(ADDR_PLL_CONTROL, 8'h20);
    wr(ADDR_PLL_CONTROL, 8'h30);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h3f);
    wr(ADDR_PLL_CONTROL, 8'h10);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h3f);
    measure(n);                `CHK({7'h00, n >= 29 && n <= 31}, 8'h01);
    // Crystal loss test with crystal running, then stopped
    wr(ADDR_PLL_BANDWIDTH, 8'h10);
    repeat (40) @(posedge clk);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h00);
    xtal_run = 1'b0;
    repeat (8) @(posedge clk); // Drain crystal edges from the synchroniser
    wr(ADDR_PLL_BANDWIDTH, 8'h10);
    repeat (40) @(posedge clk);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h10);
    xtal_run = 1'b1;
    wr(ADDR_PLL_CONTROL, 8'h20);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h00);
    measure(n);                `CHK({7'h00, n >= 19 && n <= 21}, 8'h01);
    // Manual mode: forced filter, no enable, no flag, no lock
    wr(ADDR_PLL_BANDWIDTH, 8'h20);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h20);
    `CHK({7'h00, filter_tracking}, 8'h01);
    wr(ADDR_PLL_CONTROL, 8'ha0);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    locked = 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h20);
    `CHK({7'h00, irq}, 8'h00);
    // Automatic mode: lock and tracking shown
    wr(ADDR_PLL_BANDWIDTH, 8'ha0);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'hc0);
    `CHK({6'h00, auto_bw, filter_tracking}, 8'h02);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h2f);
    wr(ADDR_PLL_CONTROL, 8'ha0);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'haf);
    // Lock loss raises flag and request until read
    locked = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK({7'h00, irq}, 8'h01);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'hef);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'haf);
    `CHK({7'h00, irq}, 8'h00);
    wr(ADDR_PLL_CONTROL, 8'he0);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'haf);
    // Flag sets with interrupt enable off
    wr(ADDR_PLL_CONTROL, 8'h20);
    locked = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK({7'h00, irq}, 8'h00);
    rd(ADDR_PLL_CONTROL, d);   `CHK(d, 8'h6f);
    tracking = 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'he0);
    // Back to manual with stored acquisition value
    wr(ADDR_PLL_BANDWIDTH, 8'h00);
    rd(ADDR_PLL_BANDWIDTH, d); `CHK(d, 8'h20);
    conclude();
  end

endmodule // pllcc_top_test
